/* File: lcc_cluster.sv */
// Behaviour
// (RL1) cluster holds exactly ten cells
// (RL2) at most six shared control lines used
// (RL3) each clock paired with its own enable
// (RL4) cells may use an individual clock enable
// (RL5) both edges need both cluster clock lines
// (RL6) four-input lookup, register, carry-select per cell
// (RL7) register acts as D, T, JK, SR
// (RL8) combinational use bypasses the register
// (RL9) two outputs, each lookup or register
// (RL10) cascade to next cell on input d
// (RL11) cluster carry-out from fourth/tenth cell only
// (RL12) normal, arithmetic, multiplier modes route inputs
// (RL13) normal mode: carry or input c
// (RL14) no register packing when carry feeds lookup
// (RL15) cluster carry-in picks chain, selects sum
// (RL16) two carry-outs from first two inputs
// (RL17) counter enable and direction from data
// (RL18) sync clear/load hit all; counter exclusivity; code only flags a counter/register mix as a status conflict
// (RL19) shared controls reach every normal/arith register
// (RL20) carry chain may start at any cell
// (RL21) alternate cells feed left/right local areas
// (RL22) async clear beats preset or load
// (RL23) chip-wide clear overrides everything
// (RL24) update only on edge with enable
`timescale 1ns/100ps
`default_nettype none

module lcc_cluster (
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    input  wire logic [7:0]                            avs_address_i,
    input  wire logic                                  avs_read_i,
    input  wire logic                                  avs_write_i,
    input  wire logic [31:0]                           avs_writedata_i,
    input  wire logic [3:0]                            avs_byteenable_i,
    output var  logic [31:0]                           avs_readdata_o,
    output var  logic                                  avs_waitrequest_o,
    input  wire logic                                  chip_wide_clear_n_i,
    input  wire lcc_pkg::lcc_ctrl_t                    ctrl_i,
    input  wire logic [lcc_pkg::LCC_CELLS-1:0][3:0]    cell_data_i,
    input  wire logic [lcc_pkg::LCC_CELLS-1:0]         cell_enable_i,
    input  wire logic                                  cluster_carry_in_i,
    input  wire logic                                  carry_chain_zero_in_i,
    input  wire logic                                  carry_chain_one_in_i,
    input  wire logic                                  cascade_in_i,
    output var  logic [lcc_pkg::LCC_CELLS-1:0]         out_a_o,
    output var  logic [lcc_pkg::LCC_CELLS-1:0]         out_b_o,
    output var  logic                                  cluster_carry_out_o,
    output var  logic                                  cascade_out_o,
    output var  logic [lcc_pkg::LCC_AREA_CELLS-1:0]    left_area_o,
    output var  logic [lcc_pkg::LCC_AREA_CELLS-1:0]    right_area_o
);

    // ========================================================================
    // configuration state
    // ========================================================================
    lcc_pkg::lcc_cell_cfg_t     cfg_q [lcc_pkg::LCC_CELLS];   // see (RL1)
    lcc_pkg::lcc_cluster_ctrl_t ctl_q;
    logic [lcc_pkg::LCC_CELLS-1:0] state_q;
    logic                          wait_q;
    logic [31:0]                   rdata_q;
    lcc_pkg::lcc_ctrl_t            ctl_prev_q;

    // ========================================================================
    // avalon slave: two cycles per access
    // ========================================================================
    logic        bus_req;
    logic        bus_commit;
    logic [5:0]  word_idx;
    logic [31:0] rd_d;

    assign bus_req    = avs_read_i | avs_write_i;
    assign bus_commit = avs_write_i & ~wait_q;
    assign word_idx   = avs_address_i[7:2];

    // lane-wise write merge
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // waitrequest low one cycle per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(bus_req & wait_q);
        end
    end

    // read data caught early, stands while waitrequest low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i & wait_q) begin
            rdata_q <= rd_d;
        end
    end

    // ========================================================================
    // cluster-wide control decoding
    // ========================================================================
    logic               overuse;
    logic               conflict;
    lcc_pkg::lcc_ctrl_t ctl_used;
    logic               tick_one;
    logic               tick_two;
    logic [3:0]         used_cnt;

    // unmarked lines are ignored
    assign ctl_used = ctrl_i & ctl_q.use_mask;

    // over six lines in use freezes clocked register updates
    always_comb begin
        used_cnt = 4'h0;
        for (int k = 0; k < lcc_pkg::LCC_CTRL_SIGS; k++) begin
            used_cnt = used_cnt + {3'h0, ctl_q.use_mask[k]};
        end
        overuse = (used_cnt > 4'(lcc_pkg::LCC_MAX_CTRL)); // see (RL2)
    end

    // clock lines are sampled levels; each line has its own edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_prev_q <= '0;
        end else begin
            ctl_prev_q <= ctl_used;
        end
    end

    // a cell needing the other edge must sit on the other line
    assign tick_one = ctl_q.one_falling ?
                      (ctl_prev_q.cluster_clock_one & ~ctl_used.cluster_clock_one) :
                      (~ctl_prev_q.cluster_clock_one & ctl_used.cluster_clock_one); // see (RL5)
    assign tick_two = ctl_q.two_falling ?
                      (ctl_prev_q.clock_two & ~ctl_used.clock_two) :
                      (~ctl_prev_q.clock_two & ctl_used.clock_two); // see (RL5)

    // ========================================================================
    // cell datapath, low cell to high cell
    // ========================================================================
    logic [lcc_pkg::LCC_CELLS-1:0] comb_res;
    logic [lcc_pkg::LCC_CELLS-1:0] ff_next;
    logic [lcc_pkg::LCC_CELLS-1:0] cell_tick;
    logic [lcc_pkg::LCC_CELLS-1:0] cell_en;
    logic [lcc_pkg::LCC_CELLS-1:0] chain_zero;
    logic [lcc_pkg::LCC_CELLS-1:0] chain_one;
    logic [lcc_pkg::LCC_CELLS-1:0] load_val;

    always_comb begin
        logic       c0;
        logic       c1;
        logic       casc;
        logic       a_in;
        logic       b_in;
        logic       carry_sel;
        logic       chosen;
        logic       sum;
        logic       in_c;
        logic       in_d;
        logic       lut;
        logic       dval;
        logic       gen;
        logic       prop;
        logic       line_en;
        logic [3:0] d;
        c0        = carry_chain_zero_in_i;
        c1        = carry_chain_one_in_i;
        casc      = cascade_in_i;
        a_in      = 1'b0;
        b_in      = 1'b0;
        carry_sel = 1'b0;
        chosen    = 1'b0;
        sum       = 1'b0;
        in_c      = 1'b0;
        in_d      = 1'b0;
        lut       = 1'b0;
        dval      = 1'b0;
        gen       = 1'b0;
        prop      = 1'b0;
        line_en   = 1'b0;
        d         = 4'h0;
        comb_res  = '0;
        ff_next   = '0;
        cell_tick = '0;
        cell_en   = '0;
        chain_zero = '0;
        chain_one = '0;
        load_val  = '0;
        for (int i = 0; i < lcc_pkg::LCC_CELLS; i++) begin
            d = cell_data_i[i];
            // a new chain assumes carry 0 and 1 at once
            if (cfg_q[i].chain_start) begin
                c0 = 1'b0; // see (RL20)
                c1 = 1'b1; // see (RL20)
            end
            // counter bits add the register to 0 (up) or all ones (down)
            a_in = cfg_q[i].counter ? state_q[i] : d[0];
            b_in = cfg_q[i].counter ? ~d[3] : d[1]; // see (RL17)
            carry_sel = cfg_q[i].counter ? d[3] : cluster_carry_in_i;
            chosen = carry_sel ? c1 : c0; // see (RL15)
            sum  = a_in ^ b_in ^ chosen; // see (RL15)
            gen  = a_in & b_in;
            prop = a_in | b_in;
            chain_zero[i] = c0 ? prop : gen; // see (RL16)
            chain_one[i]  = c1 ? prop : gen; // see (RL16)
            // normal mode lookup inputs
            in_c = cfg_q[i].c_from_carry ? chosen : d[2]; // see (RL13)
            in_d = cfg_q[i].cascade_in ? casc : d[3]; // see (RL10)
            lut  = cfg_q[i].lut_mask[{in_d, in_c, d[1], d[0]}]; // see (RL6)
            // mode routes the four inputs
            case (cfg_q[i].mode)
                lcc_pkg::LCC_MODE_NORMAL: begin
                    comb_res[i] = lut; // see (RL12)
                    dval = (cfg_q[i].pack_reg & ~cfg_q[i].c_from_carry) ?
                           d[3] : lut; // see (RL14)
                end
                lcc_pkg::LCC_MODE_ARITH,
                lcc_pkg::LCC_MODE_MULT: begin
                    comb_res[i] = sum; // see (RL12)
                    dval = sum;
                end
                default: begin
                    comb_res[i] = lut;
                    dval = lut;
                end
            endcase
            // register behaviour selected per cell
            case (cfg_q[i].ff)
                lcc_pkg::LCC_FF_D:  ff_next[i] = dval; // see (RL7)
                lcc_pkg::LCC_FF_T:  ff_next[i] = state_q[i] ^ dval; // see (RL7)
                lcc_pkg::LCC_FF_JK: ff_next[i] = (dval & ~state_q[i]) |
                                                 (~d[2] & state_q[i]); // see (RL7)
                lcc_pkg::LCC_FF_SR: ff_next[i] = dval | (~d[2] & state_q[i]); // see (RL7)
                default:            ff_next[i] = state_q[i];
            endcase
            // enable one is lent to the multiplier
            if (cfg_q[i].clock_two) begin
                line_en = ctl_used.enable_two | ~ctl_q.use_mask[3]; // see (RL3)
            end else if (cfg_q[i].mode == lcc_pkg::LCC_MODE_MULT) begin
                line_en = 1'b1;
            end else begin
                line_en = ctl_used.cluster_clock_enable_one |
                          ~ctl_q.use_mask[2]; // see (RL3)
            end
            cell_en[i] = cfg_q[i].own_enable ? cell_enable_i[i] : line_en; // see (RL4)
            if (cfg_q[i].counter) begin
                cell_en[i] = cell_en[i] & d[2]; // see (RL17)
            end
            cell_tick[i] = cfg_q[i].clock_two ? tick_two : tick_one; // see (RL19)
            load_val[i]  = d[2];
            c0   = chain_zero[i];
            c1   = chain_one[i];
            casc = comb_res[i]; // see (RL10)
        end
    end

    // a counter beside any other used register raises the conflict flag
    always_comb begin
        logic any_cnt;
        logic any_other;
        any_cnt   = 1'b0;
        any_other = 1'b0;
        for (int i = 0; i < lcc_pkg::LCC_CELLS; i++) begin
            any_cnt   = any_cnt | cfg_q[i].counter;
            any_other = any_other | (cfg_q[i].reg_used & ~cfg_q[i].counter);
        end
        conflict = any_cnt & any_other; // see (RL18)
    end

    // ========================================================================
    // cell registers
    // ========================================================================
    // async lines land at the next edge here
    // chip clear ranks first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            for (int i = 0; i < lcc_pkg::LCC_CELLS; i++) begin
                if (ctl_q.chip_clear_en & ~chip_wide_clear_n_i) begin
                    state_q[i] <= 1'b0; // see (RL23)
                end else if (ctl_used.async_clear) begin
                    state_q[i] <= 1'b0; // see (RL22)
                end else if (ctl_used.async_preset & ~ctl_q.aload_sel) begin
                    state_q[i] <= 1'b1;
                end else if (ctl_used.async_load |
                             (ctl_used.async_preset & ctl_q.aload_sel)) begin
                    state_q[i] <= load_val[i];
                end else if (!overuse && cell_tick[i] && cell_en[i]) begin // see (RL24)
                    if (ctl_used.sync_clear) begin
                        state_q[i] <= 1'b0; // see (RL18)
                    end else if (ctl_used.sync_load) begin
                        state_q[i] <= load_val[i]; // see (RL18)
                    end else begin
                        state_q[i] <= ff_next[i];
                    end
                end
            end
        end
    end

    // ========================================================================
    // cell outputs and routing areas
    // ========================================================================
    // registered: lookup results show a cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_a_o <= '0;
            out_b_o <= '0;
        end else begin
            for (int i = 0; i < lcc_pkg::LCC_CELLS; i++) begin
                out_a_o[i] <= cfg_q[i].out_a_reg ? state_q[i] : comb_res[i]; // see (RL9)
                out_b_o[i] <= cfg_q[i].out_b_reg ? state_q[i] : comb_res[i]; // see (RL8)
            end
        end
    end

    // even cells feed left, odd right
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_area_o  <= '0;
            right_area_o <= '0;
        end else begin
            for (int k = 0; k < lcc_pkg::LCC_AREA_CELLS; k++) begin
                left_area_o[k]  <= cfg_q[2*k].out_a_reg ?
                                   state_q[2*k] : comb_res[2*k]; // see (RL21)
                right_area_o[k] <= cfg_q[2*k+1].out_a_reg ?
                                   state_q[2*k+1] : comb_res[2*k+1]; // see (RL21)
            end
        end
    end

    // carry out from two cells, tenth wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cluster_carry_out_o <= 1'b0;
            cascade_out_o       <= 1'b0;
        end else begin
            cascade_out_o <= comb_res[lcc_pkg::LCC_CELLS-1];
            if (ctl_q.cout_from_ten) begin
                cluster_carry_out_o <= cluster_carry_in_i ?
                                       chain_one[lcc_pkg::LCC_COUT_HIGH] :
                                       chain_zero[lcc_pkg::LCC_COUT_HIGH]; // see (RL11)
            end else if (ctl_q.cout_from_four) begin
                cluster_carry_out_o <= cluster_carry_in_i ?
                                       chain_one[lcc_pkg::LCC_COUT_LOW] :
                                       chain_zero[lcc_pkg::LCC_COUT_LOW]; // see (RL11)
            end else begin
                cluster_carry_out_o <= 1'b0;
            end
        end
    end

    // ========================================================================
    // register file
    // ========================================================================
    // writes land on the completing edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < lcc_pkg::LCC_CELLS; i++) begin
                cfg_q[i] <= lcc_pkg::LCC_CELL_CFG_RESET;
            end
            ctl_q <= lcc_pkg::LCC_CLUSTER_CTRL_RESET;
        end else if (bus_commit) begin
            for (int i = 0; i < lcc_pkg::LCC_CELLS; i++) begin
                if (word_idx == 6'(i + 32'(lcc_pkg::LCC_CELL_CFG_BASE[7:2]))) begin
                    cfg_q[i] <= lane_merge(cfg_q[i], avs_writedata_i,
                                           avs_byteenable_i);
                end
            end
            if (word_idx == lcc_pkg::LCC_CLUSTER_CTRL_ADDR[7:2]) begin
                ctl_q <= lane_merge(ctl_q, avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        for (int i = 0; i < lcc_pkg::LCC_CELLS; i++) begin
            if (word_idx == 6'(i + 32'(lcc_pkg::LCC_CELL_CFG_BASE[7:2]))) begin
                rd_d = cfg_q[i];
            end
        end
        if (word_idx == lcc_pkg::LCC_CLUSTER_CTRL_ADDR[7:2]) begin
            rd_d = ctl_q;
        end
        if (word_idx == lcc_pkg::LCC_STATUS_ADDR[7:2]) begin
            rd_d[lcc_pkg::LCC_CELLS-1:0]          = state_q;
            rd_d[lcc_pkg::LCC_STAT_OVERUSE_BIT]  = overuse;
            rd_d[lcc_pkg::LCC_STAT_CONFLICT_BIT] = conflict;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;

endmodule

`default_nettype wire

/* File: lcc_cluster_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module lcc_cluster_bench;
    logic clk_i, rst_i, rd, wr, wt, clrn, c0, c1, cas;
    logic [7:0]        adr;
    logic [31:0]       wd, rdv, rdata;
    lcc_pkg::lcc_ctrl_t ctrl;
    logic [9:0][3:0]   dat;
    logic [9:0]        en, oa, ob;
    logic [4:0]        la, ra;
    int                err_total, checks;
    lcc_neighbour nb_u (.clk_i, .rst_i, .chain0_o(c0), .chain1_o(c1), .cascade_o(cas));
    lcc_cluster dut_u (.clk_i, .rst_i, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdv),
        .avs_waitrequest_o(wt), .chip_wide_clear_n_i(clrn), .ctrl_i(ctrl), .cell_data_i(dat),
        .cell_enable_i(en), .cluster_carry_in_i(1'b0), .carry_chain_zero_in_i(c0),
        .carry_chain_one_in_i(c1), .cascade_in_i(cas), .out_a_o(oa), .out_b_o(ob),
        .cluster_carry_out_o(), .cascade_out_o(), .left_area_o(la), .right_area_o(ra));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one access, held until waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wt !== 1'b0 && n < 20);
        rdata = rdv;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n == 20) begin
            err_total++;
            test_done();
        end
        @(posedge clk_i);
    endtask
    initial begin
        {rst_i, rd, wr, clrn, adr, wd, ctrl, dat, en, err_total, checks} = '0;
        rst_i = 1'b1;
        clrn = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // cell words, control, status, a hole
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, 8'(4 * i), '0);
            chk("reset word", rdata, '0);
            if (i < 10) bus(1'b1, 8'(4 * i), 32'h2000_0000 | i);
        end
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, 8'(4 * i), '0);
            chk("cell word", rdata, 32'h2000_0000 | i);
        end
        bus(1'b1, 8'h30, 32'hffff_ffff);
        bus(1'b0, 8'h30, '0);
        chk("hole", rdata, '0);
        $display("register test done");
        // parity lookup on both outputs
        bus(1'b1, 8'h0c, 32'h0000_6996);
        for (int v = 0; v < 16; v++) begin
            dat[3] <= 4'(v);
            repeat (3) @(posedge clk_i);
            chk("lut a", oa[3], ^4'(v));
            chk("lut b", ob[3], ^4'(v));
            chk("area", ra[1], ^4'(v));
        end
        $display("lookup test done");
        // clocked capture, hold, own enable, async lines
        bus(1'b1, 8'h00, 32'h2010_ffff);
        bus(1'b1, 8'h28, 32'h0000_0035);
        ctrl.cluster_clock_enable_one <= 1'b1;
        ctrl.cluster_clock_one <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("capture", oa[0], 1);
        bus(1'b1, 8'h00, 32'h2010_0000);
        ctrl <= '0;
        repeat (2) @(posedge clk_i);
        ctrl.cluster_clock_one <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("hold", oa[0], 1);
        chk("comb side", ob[0], 0);
        bus(1'b1, 8'h00, 32'h2090_0000);
        en[0] <= 1'b1;
        ctrl.cluster_clock_one <= 1'b0;
        repeat (2) @(posedge clk_i);
        ctrl.cluster_clock_one <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("own enable", oa[0], 0);
        ctrl.async_preset <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("preset", oa[0], 1);
        ctrl.async_clear <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("clear wins", oa[0], 0);
        ctrl.async_clear <= 1'b0;
        bus(1'b1, 8'h28, 32'h0000_0835);
        clrn <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("chip clear", oa[0], 0);
        clrn <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("preset back", oa[0], 1);
        // seven lines overuse, six fine
        bus(1'b1, 8'h28, 32'h0000_007f);
        bus(1'b0, 8'h2c, '0);
        chk("overuse", rdata[16], 1);
        bus(1'b1, 8'h28, 32'h0000_003f);
        bus(1'b0, 8'h2c, '0);
        chk("six ok", rdata[16], 0);
        $display("cell test done");
        test_done();
    end
endmodule
`default_nettype wire

/* File: lcc_cluster_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module lcc_cluster_checker (
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                avs_read_i,
    input  wire logic                                avs_write_i,
    input  wire logic [31:0]                         avs_readdata_o,
    input  wire logic                                avs_waitrequest_o,
    input  wire logic [lcc_pkg::LCC_CELLS-1:0]       out_a_o,
    input  wire logic [lcc_pkg::LCC_CELLS-1:0]       out_b_o,
    input  wire logic [lcc_pkg::LCC_AREA_CELLS-1:0]  left_area_o,
    input  wire logic [lcc_pkg::LCC_AREA_CELLS-1:0]  right_area_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========================================================================
    // bus answer: one wait cycle, then back to rest
    sequence ack_s;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    rd_wait_a: assert property (avs_read_i && avs_waitrequest_o |=> ack_s) else $error("read ack");
    wr_wait_a: assert property (avs_write_i && avs_waitrequest_o |=> ack_s) else $error("write ack");
    idle_hold_a: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("stray ack");
    ack_cause_a: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
        else $error("ack cause");
    rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("rdata moved");
    // reset check opts out of the disable
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> (out_a_o == '0)
        && (out_b_o == '0) && avs_waitrequest_o) else $error("reset state");
    // areas compared once outputs settle
    left_area_a: assert property ($stable(out_a_o) |-> left_area_o == {out_a_o[8], out_a_o[6],
        out_a_o[4], out_a_o[2], out_a_o[0]}) else $error("left area");
    right_area_a: assert property ($stable(out_a_o) |-> right_area_o == {out_a_o[9], out_a_o[7],
        out_a_o[5], out_a_o[3], out_a_o[1]}) else $error("right area");
endmodule
bind lcc_cluster lcc_cluster_checker chk_u (.clk_i, .rst_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .out_a_o, .out_b_o, .left_area_o, .right_area_o);
`default_nettype wire

/* File: lcc_neighbour.sv */
`timescale 1ns/100ps
`default_nettype none
module lcc_neighbour (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      chain0_o,
    output logic      chain1_o,
    output logic      cascade_o
);
    // ========================================================================
    // chains assume carry zero and one
    assign chain0_o = 1'b0;
    assign chain1_o = 1'b1;
    // stands in for previous cell's lookup result: toggles every cycle
    always_ff @(posedge clk_i) begin
        cascade_o <= rst_i ? 1'b0 : !cascade_o;
    end
endmodule
`default_nettype wire

/* File: lcc_pkg.sv */
`default_nettype none

package lcc_pkg;

    // ========================================================================
    // cluster shape
    // ========================================================================
    localparam int LCC_CELLS      = 10;   // cells per cluster
    localparam int LCC_CTRL_SIGS  = 9;    // shared control lines
    localparam int LCC_MAX_CTRL   = 6;    // most lines in use at once
    localparam int LCC_COUT_LOW   = 3;    // index of the fourth cell
    localparam int LCC_COUT_HIGH  = 9;    // index of the tenth cell
    localparam int LCC_AREA_CELLS = 5;    // cells feeding each local area

    // ========================================================================
    // register map (byte addresses, one word each)
    // ========================================================================
    localparam logic [7:0]  LCC_CELL_CFG_BASE      = 8'h00;
    localparam logic [7:0]  LCC_CLUSTER_CTRL_ADDR  = 8'h28;
    localparam logic [7:0]  LCC_STATUS_ADDR        = 8'h2c;
    localparam logic [31:0] LCC_CELL_CFG_RESET     = 32'h0000_0000;
    localparam logic [31:0] LCC_CLUSTER_CTRL_RESET = 32'h0000_0000;
    localparam int          LCC_STAT_OVERUSE_BIT   = 16;
    localparam int          LCC_STAT_CONFLICT_BIT  = 17;

    // ========================================================================
    // modes and field layouts
    // ========================================================================
    typedef enum logic [1:0] {
        LCC_MODE_NORMAL = 2'h0,
        LCC_MODE_ARITH  = 2'h1,
        LCC_MODE_MULT   = 2'h2,
        LCC_MODE_RSVD   = 2'h3
    } lcc_mode_t;

    typedef enum logic [1:0] {
        LCC_FF_D  = 2'h0,
        LCC_FF_T  = 2'h1,
        LCC_FF_JK = 2'h2,
        LCC_FF_SR = 2'h3
    } lcc_ff_t;

    // per-cell configuration word
    typedef struct packed {
        logic [1:0]  spare;        // 31:30 read back as written
        logic        reg_used;     // 29 register holds state
        logic        counter;      // 28 cell is a counter bit
        logic        chain_start;  // 27 carry chain begins here
        logic        pack_reg;     // 26 register fed from lut_input_d
        logic        cascade_in;   // 25 lut_input_d from previous cell
        logic        c_from_carry; // 24 lut input c from carry
        logic        own_enable;   // 23 individual clock enable
        logic        clock_two;    // 22 use cluster clock two
        logic        out_b_reg;    // 21 output b from register
        logic        out_a_reg;    // 20 output a from register
        lcc_ff_t     ff;           // 19:18
        lcc_mode_t   mode;         // 17:16
        logic [15:0] lut_mask;     // 15:0 truth table
    } lcc_cell_cfg_t;

    // cluster control word
    typedef struct packed {
        logic [15:0] spare;         // 31:16
        logic        aload_sel;     // 15 async preset line loads data
        logic        cout_from_ten; // 14
        logic        cout_from_four;// 13
        logic        rsvd12;        // 12
        logic        chip_clear_en; // 11
        logic        two_falling;   // 10 clock two acts on falling edge
        logic        one_falling;   // 9 clock one acts on falling edge
        logic [8:0]  use_mask;      // 8:0 shared lines in use
    } lcc_cluster_ctrl_t;

    // shared control lines, same order as use_mask
    typedef struct packed {
        logic sync_load;
        logic sync_clear;
        logic async_load;
        logic async_preset;
        logic async_clear;
        logic enable_two;
        logic cluster_clock_enable_one;
        logic clock_two;
        logic cluster_clock_one;
    } lcc_ctrl_t;

endpackage

`default_nettype wire
